/* hdl/dbw_alarm.sv */
// Dump body and gate warning lamps and beepers with an Avalon-MM port.
//
// Function
// - Active input, brake set, slow: steady lamp.
// - Active input, moving: flash 0.6 s, moving beeper.
// - Inactive input keeps its lamp dark.
// - Body level: 0 open, 1 ground, 3 high.
// - Gate level code uses the same encoding.
// - Cadence codes: off, five fast, three slow, continuous.
// - Separate moving cadences per input, default one.
// - Separate stationary cadences per input, default silent.
module dbw_alarm #(
  parameter int unsigned TICK_CYCLES = dbw_pkg::TICK_CYCLES_DFLT
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire dbw_pkg::dbw_pins_t pins_i,
  input wire dbw_pkg::dbw_av_req_t av_i,
  output dbw_pkg::dbw_av_rsp_t av_o,
  output logic body_lamp_o,
  output logic gate_lamp_o,
  output logic body_beep_o,
  output logic gate_beep_o
);
  import dbw_pkg::*;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  dbw_state_t s_reg;
  dbw_state_t s_next;
  logic b_act;
  logic g_act;
  logic moving;
  logic b_stat;
  logic b_mov;
  logic g_stat;
  logic g_mov;
  logic b_start;
  logic g_start;
  dbw_cad_t b_cad;
  dbw_cad_t g_cad;
  logic [31:0] status;

  // Level code 2 falls through to no match.
  function automatic logic lvl_match(input logic [1:0] lvl,
                                     input logic high,
                                     input logic gnd);
    logic m;
    m = 1'b0;
    case (lvl)
      LVL_OPEN: m = !high && !gnd;
      LVL_GND: m = gnd;
      LVL_HIGH: m = high;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  always_comb begin
    b_act = lvl_match(s_reg.cfg.body_active_level, s_reg.stable.body_high,
                      s_reg.stable.body_gnd);
    g_act = lvl_match(s_reg.cfg.gate_active_level, s_reg.stable.gate_high,
                      s_reg.stable.gate_gnd);
    moving = !s_reg.stable.brake_set || s_reg.stable.speed_over;
    b_stat = b_act && !moving;
    b_mov = b_act && moving;
    g_stat = g_act && !moving;
    g_mov = g_act && moving;
    b_start = (b_stat && !s_reg.prev[0]) || (b_mov && !s_reg.prev[1]);
    g_start = (g_stat && !s_reg.prev[2]) || (g_mov && !s_reg.prev[3]);
    b_cad = dbw_cad_t'(b_mov ? s_reg.cfg.body_moving_cadence :
                               s_reg.cfg.body_stationary_cadence);
    g_cad = dbw_cad_t'(g_mov ? s_reg.cfg.gate_moving_cadence :
                               s_reg.cfg.gate_stationary_cadence);
    status = '0;
    status[ST_BODY_ACT] = b_act;
    status[ST_GATE_ACT] = g_act;
    status[ST_BRAKE] = s_reg.stable.brake_set;
    status[ST_SPEED] = s_reg.stable.speed_over;
    status[ST_BODY_LAMP] = s_reg.body_lamp;
    status[ST_GATE_LAMP] = s_reg.gate_lamp;
    status[ST_BODY_BEEP] = body_beep_o;
    status[ST_GATE_BEEP] = gate_beep_o;
    status[ST_FLASH] = s_reg.flash_ph;
  end

  always_comb begin
    s_next = s_reg;
    // Only the second and third stages are compared, so a bit that changes
    // while being sampled is accepted one clock later rather than glitching.
    s_next.sync1 = pins_i;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    s_next.stable = (s_reg.sync2 & ~(s_reg.sync2 ^ s_reg.sync3)) |
                    (s_reg.stable & (s_reg.sync2 ^ s_reg.sync3));

    s_next.tick = 1'b0;
    if (s_reg.tick_cnt >= TICK_CNT_W'(TICK_CYCLES - 1)) begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + TICK_CNT_W'(1);
    end

    if (s_reg.tick) begin
      if (s_reg.flash_cnt >= PH_CNT_W'(FLASH_TICKS - 1)) begin
        s_next.flash_cnt = '0;
        s_next.flash_ph = !s_reg.flash_ph;
      end else begin
        s_next.flash_cnt = s_reg.flash_cnt + PH_CNT_W'(1);
      end
    end

    s_next.body_lamp = b_stat || (b_mov && s_reg.flash_ph);
    s_next.gate_lamp = g_stat || (g_mov && s_reg.flash_ph);
    s_next.prev = {g_mov, g_stat, b_mov, b_stat};

    // One wait cycle per access: read data is loaded on the first edge, write data on the
    // completing edge, and waitrequest drops for exactly the completing cycle.
    if (!s_reg.waitreq) begin
      s_next.waitreq = 1'b1;
      if (av_i.write && av_i.address[3:2] == CFG_OFFSET[3:2]) begin
        if (av_i.byteenable[0]) begin
          s_next.cfg[7:0] = av_i.writedata[7:0];
        end
        if (av_i.byteenable[1]) begin
          s_next.cfg[11:8] = av_i.writedata[11:8];
        end
      end
    end else if (av_i.read || av_i.write) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = '0;
      if (av_i.read) begin
        case (av_i.address[3:2])
          CFG_OFFSET[3:2]: s_next.rdata = {20'h00000, s_reg.cfg};
          STATUS_OFFSET[3:2]: s_next.rdata = status;
          default: s_next.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  dbw_cadence u_body_cad (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_i(s_reg.tick),
    .enable_i(b_stat || b_mov),
    .start_i(b_start),
    .cadence_i(b_cad),
    .beep_o(body_beep_o)
  );

  dbw_cadence u_gate_cad (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_i(s_reg.tick),
    .enable_i(g_stat || g_mov),
    .start_i(g_start),
    .cadence_i(g_cad),
    .beep_o(gate_beep_o)
  );

  assign av_o.readdata = s_reg.rdata;
  assign av_o.waitrequest = s_reg.waitreq;
  assign body_lamp_o = s_reg.body_lamp;
  assign gate_lamp_o = s_reg.gate_lamp;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  a_lamp_steady: assert property (
    (b_stat || g_stat) |=> ((body_lamp_o || !$past(b_stat)) &&
    (gate_lamp_o || !$past(g_stat))))
    else $error("stationary lamp not steady");
  a_lamp_flash: assert property (
    b_mov |=> (body_lamp_o == $past(s_reg.flash_ph)))
    else $error("moving lamp not following flash phase");
  a_flash_period: assert property (
    $changed(s_reg.flash_ph) |->
    (s_reg.flash_cnt == '0 && $past(s_reg.tick)))
    else $error("flash phase toggled off its period");
  a_tick_pulse: assert property (s_reg.tick |=> !s_reg.tick)
    else $error("time base tick longer than one cycle");
  a_lamp_dark: assert property (!b_act |=> !body_lamp_o)
    else $error("body lamp lit while inactive");
  a_gate_dark: assert property (!g_act |=> !gate_lamp_o)
    else $error("gate lamp lit while inactive");
  a_body_level: assert property (
    (s_reg.cfg.body_active_level == LVL_HIGH && !moving &&
    s_reg.stable.body_high) |=> body_lamp_o)
    else $error("body high level not taken as active");
  a_gate_level: assert property (
    (s_reg.cfg.gate_active_level == LVL_OPEN && !moving &&
    !s_reg.stable.gate_high && !s_reg.stable.gate_gnd) |=> gate_lamp_o)
    else $error("gate open level not taken as active");
  a_level_two: assert property (
    (s_reg.cfg.body_active_level == LVL_NONE) |=>
    (!body_beep_o && !body_lamp_o)) else $error("level code two matched");
  a_gate_level_two: assert property (
    (s_reg.cfg.gate_active_level == LVL_NONE) |=>
    (!gate_beep_o && !gate_lamp_o)) else $error("gate code two matched");
  a_moving_beep: assert property (
    (b_mov && !s_reg.prev[1] && s_reg.cfg.body_moving_cadence != CAD_OFF)
    |=> body_beep_o) else $error("moving cadence did not start");
  a_gate_moving_beep: assert property (
    (g_mov && !s_reg.prev[3] && s_reg.cfg.gate_moving_cadence != CAD_OFF)
    |=> gate_beep_o) else $error("gate moving cadence did not start");
  a_stat_beep: assert property (
    (g_stat && !s_reg.prev[2] &&
    s_reg.cfg.gate_stationary_cadence != CAD_OFF) |=> gate_beep_o)
    else $error("stationary cadence did not start");
  a_body_stat_beep: assert property (
    (b_stat && !s_reg.prev[0] &&
    s_reg.cfg.body_stationary_cadence != CAD_OFF) |=> body_beep_o)
    else $error("body stationary cadence did not start");
  a_bus_answer: assert property (
    (av_i.read || av_i.write) && s_reg.waitreq
    |=> !av_o.waitrequest ##1 av_o.waitrequest)
    else $error("bus answer not one cycle");

endmodule // dbw_alarm

/* hdl/dbw_cadence.sv */
// Beeper cadence generator for one warning channel.
module dbw_cadence (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic start_i,
  input wire dbw_pkg::dbw_cad_t cadence_i,
  output logic beep_o
);
  import dbw_pkg::*;

  dbw_cad_state_t s_reg;
  dbw_cad_state_t s_next;
  logic [PH_CNT_W-1:0] len;

  assign beep_o = s_reg.beep;

  always_comb begin
    s_next = s_reg;
    len = (cadence_i == CAD_SLOW) ? PH_CNT_W'(SLOW_TICKS - 1) :
                                    PH_CNT_W'(FAST_TICKS - 1);
    if (!enable_i || cadence_i == CAD_OFF) begin
      s_next.st = BP_IDLE;
      s_next.cnt = '0;
      s_next.left = '0;
    end else if (start_i) begin
      s_next.st = BP_ON;
      s_next.cnt = '0;
      s_next.left = (cadence_i == CAD_SLOW) ? 3'(SLOW_BEEPS) : 3'(FAST_BEEPS);
    end else if (cadence_i == CAD_CONT) begin
      if (s_reg.st != BP_IDLE) begin
        s_next.st = BP_ON;
      end
    end else if (tick_i) begin
      case (s_reg.st)
        BP_ON: begin
          if (s_reg.cnt >= len) begin
            s_next.cnt = '0;
            s_next.st = BP_GAP;
            s_next.left = s_reg.left - 3'h1;
          end else begin
            s_next.cnt = s_reg.cnt + PH_CNT_W'(1);
          end
        end
        BP_GAP: begin
          if (s_reg.cnt >= len) begin
            s_next.cnt = '0;
            s_next.st = (s_reg.left == 3'h0) ? BP_IDLE : BP_ON;
          end else begin
            s_next.cnt = s_reg.cnt + PH_CNT_W'(1);
          end
        end
        BP_IDLE: begin
          s_next.cnt = '0;
        end
        default: begin
          s_next.st = BP_IDLE;
        end
      endcase
    end
    s_next.beep = (s_next.st == BP_ON);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg.st <= BP_IDLE;
      s_reg.cnt <= '0;
      s_reg.left <= '0;
      s_reg.beep <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  a_cad_stop: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !enable_i |=> !beep_o) else $error("beeper sounds without condition");
  a_cad_restart: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (enable_i && start_i && cadence_i != CAD_OFF) |=> beep_o)
    else $error("cadence did not restart");
  a_cad_silent: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (cadence_i == CAD_OFF) |=> !beep_o) else $error("silent cadence beeps");
  a_cad_continuous: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (enable_i && cadence_i == CAD_CONT && beep_o) |=> beep_o)
    else $error("continuous cadence broke off");
  a_cad_fast_len: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (enable_i && start_i && cadence_i == CAD_FAST) ##1
    (enable_i && !start_i && cadence_i == CAD_FAST && !tick_i) [*3]
    |-> beep_o) else $error("fast beep ended early");

endmodule // dbw_cadence

/* hdl/dbw_pkg.sv */
// Shared constants, types and register layout of the dump body warning block.
package dbw_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 32;

  // Lamp flash and beep timing, in milliseconds and in ticks.
  localparam int FLASH_MS = 600;
  localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
  localparam int FAST_BEEP_MS = 100;
  localparam int FAST_TICKS = FAST_BEEP_MS / TICK_MS;
  localparam int SLOW_BEEP_MS = 300;
  localparam int SLOW_TICKS = SLOW_BEEP_MS / TICK_MS;
  localparam int FAST_BEEPS = 5;
  localparam int SLOW_BEEPS = 3;
  localparam int PH_CNT_W = 7;

  // Register map, byte addresses.
  localparam logic [3:0] CFG_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Active level codes of a switch input.
  localparam logic [1:0] LVL_OPEN = 2'h0;
  localparam logic [1:0] LVL_GND = 2'h1;
  localparam logic [1:0] LVL_NONE = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  typedef enum logic [1:0] {
    CAD_OFF = 2'h0,
    CAD_FAST = 2'h1,
    CAD_SLOW = 2'h2,
    CAD_CONT = 2'h3
  } dbw_cad_t;

  typedef enum logic [2:0] {
    BP_IDLE = 3'h1,
    BP_ON = 3'h2,
    BP_GAP = 3'h4
  } dbw_beep_st_t;

  // Configuration register, high bit first: body level at [1:0].
  typedef struct packed {
    logic [1:0] gate_stationary_cadence;
    logic [1:0] gate_moving_cadence;
    logic [1:0] body_stationary_cadence;
    logic [1:0] body_moving_cadence;
    logic [1:0] gate_active_level;
    logic [1:0] body_active_level;
  } dbw_cfg_t;

  localparam int CFG_W = 12;
  localparam logic [11:0] CFG_RESET = 12'h11F;

  // Status register bit positions.
  localparam int ST_BODY_ACT = 0;
  localparam int ST_GATE_ACT = 1;
  localparam int ST_BRAKE = 2;
  localparam int ST_SPEED = 3;
  localparam int ST_BODY_LAMP = 4;
  localparam int ST_GATE_LAMP = 5;
  localparam int ST_BODY_BEEP = 6;
  localparam int ST_GATE_BEEP = 7;
  localparam int ST_FLASH = 8;

  typedef struct packed {
    logic speed_over;
    logic brake_set;
    logic gate_gnd;
    logic gate_high;
    logic body_gnd;
    logic body_high;
  } dbw_pins_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } dbw_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } dbw_av_rsp_t;

  typedef struct packed {
    dbw_beep_st_t st;
    logic [PH_CNT_W-1:0] cnt;
    logic [2:0] left;
    logic beep;
  } dbw_cad_state_t;

  typedef struct packed {
    dbw_pins_t sync1;
    dbw_pins_t sync2;
    dbw_pins_t sync3;
    dbw_pins_t stable;
    dbw_cfg_t cfg;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic [PH_CNT_W-1:0] flash_cnt;
    logic flash_ph;
    logic body_lamp;
    logic gate_lamp;
    logic [3:0] prev;
    logic waitreq;
    logic [31:0] rdata;
  } dbw_state_t;

endpackage : dbw_pkg

/* tb/dbw_alarm_test.sv */
// Self-checking testbench of the dump body warning block.
module dbw_alarm_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dbw_pkg::*;
  // A short time base keeps the 0.6 s flash and beep runs brief.
  localparam int TC = 4;
  localparam int FLASH_CYC = FLASH_TICKS * TC;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] body_st = 2'h0;
  logic [1:0] gate_st = 2'h0;
  logic brake = 1'b0;
  logic speed = 1'b0;
  dbw_pins_t pins;
  dbw_av_req_t av_i = '0;
  dbw_av_rsp_t av_o;
  logic body_lamp;
  logic gate_lamp;
  logic body_beep;
  logic gate_beep;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;
  int hi;
  logic [31:0] rd;
  logic [4:0] r;
  // Rows: level code, contact state, expected active.
  logic [4:0] rows [12] = '{5'h01, 5'h02, 5'h06, 5'h0B, 5'h08, 5'h0E,
                            5'h10, 5'h12, 5'h16, 5'h1F, 5'h18, 5'h1A};
  int exp_beeps [4] = '{0, 5, 3, 1};

  always #2.5 clk_sys_i = ~clk_sys_i;

  dbw_partner partner (
    .body_state_i(body_st),
    .gate_state_i(gate_st),
    .brake_set_i(brake),
    .speed_over_i(speed),
    .pins_o(pins)
  );

  dbw_alarm #(.TICK_CYCLES(TC)) dut (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .pins_i(pins),
    .av_i(av_i),
    .av_o(av_o),
    .body_lamp_o(body_lamp),
    .gate_lamp_o(gate_lamp),
    .body_beep_o(body_beep),
    .gate_beep_o(gate_beep)
  );

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    av_i.read <= !wr;
    av_i.write <= wr;
    av_i.address <= a;
    av_i.writedata <= d;
    av_i.byteenable <= 4'hF;
    @(posedge clk_sys_i);
    // Only the watchdog ends a wait for the answer.
    while (av_o.waitrequest !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    rd = av_o.readdata;
    av_i.read <= 1'b0;
    av_i.write <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic setp(input logic [1:0] b, input logic [1:0] g,
                      input logic br, input logic sp);
    body_st <= b;
    gate_st <= g;
    brake <= br;
    speed <= sp;
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic watch(input int n);
    logic p;
    p = body_beep;
    cnt = 0;
    hi = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      if (body_beep === 1'b1 && p !== 1'b1) cnt++;
      if (body_beep === 1'b1) hi++;
      p = body_beep;
    end
  endtask

  task automatic toggle_wait();
    logic p;
    p = body_lamp;
    cnt = 0;
    while (body_lamp === p && cnt < 600) begin
      @(posedge clk_sys_i);
      cnt++;
    end
    chk("lamp toggled", 32'h1, body_lamp !== p);
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    chk("waitrequest in reset", 32'h1, av_o.waitrequest);
    chk("outputs in reset", 32'h0,
        {body_lamp, gate_lamp, body_beep, gate_beep});
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    bus(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg reset", 32'h11F, rd);
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      bus(1'b1, CFG_OFFSET, {28'h0, r[4:3], r[4:3]});
      setp(r[2:1], r[2:1], 1'b1, 1'b0);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk("status bits", {24'h0, 2'h0, r[0], r[0], 2'h1, r[0], r[0]},
          rd & 32'hFF);
      chk("lamps", {30'h0, r[0], r[0]}, {body_lamp, gate_lamp});
      chk("beeps", 32'h0, {body_beep, gate_beep});
    end
    // Each run enters the moving condition afresh, so the pattern restarts.
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, CFG_OFFSET, 32'h10F | (32'(c) << 4));
      setp(2'h3, 2'h0, 1'b1, 1'b0);
      speed <= 1'b1;
      watch(900);
      chk("moving beeps", exp_beeps[c], cnt);
    end
    chk("continuous", 32'h1, hi >= 880);
    toggle_wait();
    toggle_wait();
    chk("flash half period", FLASH_CYC, cnt);
    chk("gate lamp dark", 32'h0, gate_lamp);
    setp(2'h3, 2'h0, 1'b1, 1'b0);
    chk("beep stops", 32'h0, body_beep);
    chk("steady lamp", 32'h1, body_lamp);
    bus(1'b1, CFG_OFFSET, 32'h19F);
    setp(2'h0, 2'h3, 1'b1, 1'b0);
    body_st <= 2'h3;
    watch(900);
    chk("stationary beeps", 32'h3, cnt);
    chk("gate stationary", 32'h2, {gate_lamp, gate_beep});
    bus(1'b1, CFG_OFFSET, 32'h30F);
    setp(2'h3, 2'h3, 1'b0, 1'b0);
    chk("moving per input", 32'h1, {body_beep, gate_beep});
    bus(1'b1, 4'h8, 32'hFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg kept", 32'h30F, rd);
    // A reset in mid-run must silence everything and restore the defaults.
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk("outputs in mid reset", 32'h0,
        {body_lamp, gate_lamp, body_beep, gate_beep});
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    bus(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg after reset", 32'h11F, rd);
    summarize();
  end
endmodule // dbw_alarm_test

/* tb/dbw_partner.sv */
// Behavioural model of the body and gate switches, brake and speed source.
module dbw_partner (
  input wire logic [1:0] body_state_i,
  input wire logic [1:0] gate_state_i,
  input wire logic brake_set_i,
  input wire logic speed_over_i,
  output dbw_pkg::dbw_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbw_pkg::*;
  // A contact reads as 12 V, ground or open; code 2 is left open on purpose.
  always_comb begin
    pins_o.body_high = (body_state_i == LVL_HIGH);
    pins_o.body_gnd = (body_state_i == LVL_GND);
    pins_o.gate_high = (gate_state_i == LVL_HIGH);
    pins_o.gate_gnd = (gate_state_i == LVL_GND);
    pins_o.brake_set = brake_set_i;
    pins_o.speed_over = speed_over_i;
  end
endmodule // dbw_partner
